// File: rtl/tcr_pkg.sv
// register offsets, field positions, reset values and timing for the control bank
package tcr_pkg;
    // register indices (byte address is four times the index)
    localparam logic [3:0] IDX_BAND = 4'h1;
    localparam logic [3:0] IDX_LVL = 4'h2;
    localparam logic [3:0] IDX_RXFREQ = 4'ha;
    localparam logic [3:0] IDX_GAIN = 4'hb;
    localparam logic [3:0] IDX_STEPS = 4'hc;
    localparam logic [3:0] IDX_DUR = 4'hd;
    localparam logic [3:0] IDX_INTEG = 4'he;
    // own registers: status readback and mode control
    localparam logic [3:0] IDX_STATUS = 4'h0;
    localparam logic [3:0] IDX_MODE = 4'hf;
    // field positions
    localparam int TX_BAND_BIT = 4;
    localparam int RX_BAND_LO = 1;
    localparam int LVL_BIT = 1;
    localparam int SRST_BIT = 0;
    localparam int GAIN_W = 7;
    localparam int GAIN_CAL_LO = 1;
    // reset values
    localparam logic [15:0] RST_BAND = 16'h0004;
    localparam logic [15:0] RST_LVL = 16'h0002;
    localparam logic [15:0] RST_RXFREQ = 16'h9858;
    localparam logic [15:0] RST_GAIN = 16'h0000;
    localparam logic [15:0] RST_STEPS = 16'h0fa6;
    localparam logic [15:0] RST_DUR = 16'h103e;
    localparam logic [15:0] RST_INTEG = 16'he000;
    localparam logic [15:0] RST_CAL = 16'h0010;
    // gain mode constants
    localparam logic [7:0] MODE_K_WIDE = 8'h08;
    localparam logic [7:0] MODE_K_NARROW = 8'h11;
    // soft reset pulse timing
    localparam int SRST_NS = 50000;
    localparam int CLK_NS = 10;
    localparam int SRST_CYCLES = SRST_NS / CLK_NS;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: rtl/tcr_pulse_if.sv
// carrier between the bank and its soft reset pulse timer
`timescale 1ns/1ns
interface tcr_pulse_if;
    logic start; // one-cycle launch request
    logic busy; // pulse in progress
    modport bank (output start, input busy);
    modport timer (input start, output busy);
endinterface

// File: rtl/tcr_pulse_timer.sv
// soft reset pulse timer: holds busy for a fixed count of cycles
`timescale 1ns/1ns
module tcr_pulse_timer
    import tcr_pkg::*;
#(
    parameter int CYCLES = SRST_CYCLES
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // launch and status
    tcr_pulse_if.timer pls
);
    logic [15:0] cnt_ff; // cycles left in the pulse

    // restart on every launch; the bank launches only while idle, so an edge written mid-pulse gives no pulse
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_ff <= 16'h0000;
        else if (pls.start)
            cnt_ff <= 16'(CYCLES);
        else if (cnt_ff != 16'h0000)
            cnt_ff <= cnt_ff - 16'h0001;
    end

    assign pls.busy = (cnt_ff != 16'h0000);
endmodule

// File: rtl/tcr_regs.sv
// write-only transceiver control bank behind an axi4-lite slave
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
module tcr_regs
    import tcr_pkg::*;
#(
    parameter int SRST_LEN = SRST_CYCLES
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // band selects
    output logic tx_high_port,
    output logic tx_low_port,
    output logic rx_low_port,
    output logic rx_high_port_one,
    output logic rx_high_port_two,
    // interface supply and chip reset
    output logic interface_level_select,
    output logic chip_reset,
    // receive path settings
    output logic [15:0] rx_synth_word,
    output logic [7:0] rx_gain_db,
    output logic [3:0] skip_mask,
    output logic [3:0] sdm_enable_mask,
    output logic [3:0] mixer_threshold,
    output logic [3:0] lna_threshold,
    output logic [3:0] offset_adc_range_mask,
    output logic [3:0] state2_duration,
    output logic [3:0] state1_duration,
    output logic [3:0] state0_duration,
    output logic [3:0] state3_integrator_constant
);
    // write handshake phases
    typedef enum logic [1:0] {W_IDLE, W_RESP} tcr_wstate_t;

    tcr_wstate_t wst_ff; // write channel phase
    logic aw_got_ff; // address held
    logic w_got_ff; // data held
    logic [3:0] aw_idx_ff; // latched register index
    logic [15:0] w_data_ff; // latched low half word
    logic [3:0] w_strb_ff; // latched byte enables
    logic [1:0] bresp_ff; // pending write answer
    logic rvalid_ff; // read answer pending
    logic [31:0] rdata_ff; // read data
    logic [1:0] rresp_ff; // read answer code
    logic [15:0] band_ff; // band and synth enables
    logic [15:0] lvl_ff; // level and soft reset bit
    logic [15:0] rxfreq_ff; // synth word
    logic [15:0] gain_ff; // gain word
    logic [15:0] steps_ff; // offset loop steps
    logic [15:0] dur_ff; // offset loop durations
    logic [15:0] integ_ff; // offset loop integrators
    logic [15:0] mode_ff; // mode bit 0 and calibration 5:1
    logic wr_fire; // commit this cycle
    logic wr_ok; // commit is a whole word to a mapped register
    logic [15:0] wr_word; // whole word being committed
    logic [7:0] gain_sum; // intermediate gain value
    tcr_pulse_if pls();

    // map an index to a mapped writable register
    function automatic logic idx_writable(input logic [3:0] idx);
        return idx == IDX_BAND || idx == IDX_LVL || idx == IDX_RXFREQ ||
            idx == IDX_GAIN || idx == IDX_STEPS || idx == IDX_DUR ||
            idx == IDX_INTEG || idx == IDX_MODE;
    endfunction

    // address and data arrive in any order; each ready drops once held
    assign s_axi_awready = (wst_ff == W_IDLE) && !aw_got_ff;
    assign s_axi_wready = (wst_ff == W_IDLE) && !w_got_ff;
    assign s_axi_bvalid = (wst_ff == W_RESP);
    assign s_axi_bresp = bresp_ff;
    assign wr_fire = (wst_ff == W_IDLE) && aw_got_ff && w_got_ff;
    // partial writes are refused: a register updates only as a whole word
    assign wr_ok = idx_writable(aw_idx_ff) && (w_strb_ff[1:0] == 2'h3);
    assign wr_word = w_data_ff;

    // address capture
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_ff <= 1'b0;
            aw_idx_ff <= 4'h0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_got_ff <= 1'b1;
            aw_idx_ff <= s_axi_awaddr[5:2];
        end
        else if (wr_fire)
            aw_got_ff <= 1'b0;
    end

    // data capture
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_got_ff <= 1'b0;
            w_data_ff <= 16'h0000;
            w_strb_ff <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_got_ff <= 1'b1;
            w_data_ff <= s_axi_wdata[15:0];
            w_strb_ff <= s_axi_wstrb;
        end
        else if (wr_fire)
            w_got_ff <= 1'b0;
    end

    // write phase and answer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wst_ff <= W_IDLE;
            bresp_ff <= RESP_OKAY;
        end
        else
        begin
            case (wst_ff)
                W_IDLE:
                begin
                    if (wr_fire)
                    begin
                        wst_ff <= W_RESP;
                        bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                W_RESP:
                begin
                    if (s_axi_bready)
                        wst_ff <= W_IDLE;
                end
                default:
                    wst_ff <= W_IDLE;
            endcase
        end
    end

    // register bank; soft reset returns every field to its default
    always_ff @(posedge aclk)
    begin
        if (!aresetn || pls.busy)
        begin
            band_ff <= RST_BAND;
            lvl_ff <= RST_LVL;
            rxfreq_ff <= RST_RXFREQ;
            gain_ff <= RST_GAIN;
            steps_ff <= RST_STEPS;
            dur_ff <= RST_DUR;
            integ_ff <= RST_INTEG;
            mode_ff <= RST_CAL;
        end
        else if (wr_fire && wr_ok)
        begin
            case (aw_idx_ff)
                IDX_BAND: band_ff <= wr_word;
                IDX_LVL: lvl_ff <= wr_word;
                IDX_RXFREQ: rxfreq_ff <= wr_word;
                IDX_GAIN: gain_ff <= wr_word;
                IDX_STEPS: steps_ff <= wr_word;
                IDX_DUR: dur_ff <= wr_word;
                IDX_INTEG: integ_ff <= wr_word;
                IDX_MODE: mode_ff <= wr_word;
                default: ;
            endcase
        end
        else
            lvl_ff[SRST_BIT] <= 1'b0;
    end

    // launch on a 0 to 1 change of the bit; it has self-cleared since any earlier write
    assign pls.start = wr_fire && wr_ok && aw_idx_ff == IDX_LVL &&
        wr_word[SRST_BIT] && !lvl_ff[SRST_BIT] && !pls.busy;

    tcr_pulse_timer #(
        .CYCLES(SRST_LEN)
    ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .pls(pls)
    );

    // read channel: status word only, the bank itself is write-only
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_ff <= 1'b1;
            if (s_axi_araddr[5:2] == IDX_STATUS)
            begin
                rdata_ff <= {31'h0000_0000, pls.busy};
                rresp_ff <= RESP_OKAY;
            end
            else
            begin
                rdata_ff <= 32'h0000_0000;
                rresp_ff <= RESP_SLVERR;
            end
        end
        else if (s_axi_rready)
            rvalid_ff <= 1'b0;
    end

    // band outputs decoded from the written fields
    assign tx_high_port = band_ff[TX_BAND_BIT];
    assign tx_low_port = !band_ff[TX_BAND_BIT];
    assign rx_low_port = band_ff[RX_BAND_LO +: 2] == 2'h1;
    assign rx_high_port_one = band_ff[RX_BAND_LO +: 2] == 2'h2;
    assign rx_high_port_two = band_ff[RX_BAND_LO +: 2] == 2'h3;
    assign interface_level_select = lvl_ff[LVL_BIT];
    assign chip_reset = pls.busy;
    assign rx_synth_word = rxfreq_ff;

    // effective gain: setting minus calibration plus mode constant
    assign gain_sum = {1'b0, gain_ff[GAIN_W-1:0]} - {3'h0, mode_ff[GAIN_CAL_LO +: 5]}
        + (mode_ff[0] ? MODE_K_NARROW : MODE_K_WIDE);
    assign rx_gain_db = gain_sum;
    assign skip_mask = steps_ff[15:12];
    assign sdm_enable_mask = steps_ff[11:8];
    assign mixer_threshold = steps_ff[7:4];
    assign lna_threshold = steps_ff[3:0];
    assign offset_adc_range_mask = dur_ff[15:12];
    assign state2_duration = dur_ff[11:8];
    assign state1_duration = dur_ff[7:4];
    assign state0_duration = dur_ff[3:0];
    assign state3_integrator_constant = integ_ff[15:12];

    // busy cycles of the running pulse, so its exact length can be checked
    logic [15:0] pulse_len_ff; // cycles seen in the current pulse

    // counts while busy and clears between pulses; only the checks read it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pulse_len_ff <= 16'h0000;
        else if (pls.busy)
            pulse_len_ff <= pulse_len_ff + 16'h0001;
        else
            pulse_len_ff <= 16'h0000;
    end

    // soft reset pulse: launched by the edge, held, and exactly the programmed length
    a_pulse_launch: assert property (@(posedge aclk) disable iff (!aresetn)
        pls.start |=> chip_reset) else $error("soft reset not launched");
    a_pulse_len: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(chip_reset) |-> chip_reset [*8]) else $error("reset pulse too short");
    a_pulse_exact: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(chip_reset) |-> pulse_len_ff == 16'(SRST_LEN))
        else $error("reset pulse length wrong");
    // defaults come back while the pulse runs, the level bit included
    a_level_default: assert property (@(posedge aclk) disable iff (!aresetn)
        chip_reset |=> interface_level_select) else $error("level not 2.8 V");
    a_srst_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(lvl_ff[SRST_BIT]) |=> !lvl_ff[SRST_BIT]) else $error("bit stuck");
    a_reset_deflt: assert property (@(posedge aclk)
        disable iff (!aresetn) $fell(chip_reset) |->
        skip_mask == 4'h0 && sdm_enable_mask == 4'hf
        && state0_duration == 4'he && state3_integrator_constant == 4'he)
        else $error("defaults lost");
    // band and level fields follow the written word
    a_tx_select: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_high_port != tx_low_port) else $error("tx port clash");
    a_band_write: assert property (@(posedge aclk) disable iff (!aresetn || pls.busy)
        wr_fire && wr_ok && aw_idx_ff == IDX_BAND |=>
        tx_high_port == $past(wr_word[TX_BAND_BIT])) else $error("tx band not stored");
    a_rx_onehot: assert property (@(posedge aclk) disable iff (!aresetn)
        $onehot0({rx_low_port, rx_high_port_one, rx_high_port_two}))
        else $error("rx port clash");
    a_level_bit: assert property (@(posedge aclk) disable iff (!aresetn || pls.busy)
        wr_fire && wr_ok && aw_idx_ff == IDX_LVL |=>
        interface_level_select == $past(wr_word[LVL_BIT])) else $error("level bit wrong");
    // whole-word stores and refusals
    a_write_whole: assert property (@(posedge aclk)
        disable iff (!aresetn || pls.busy)
        wr_fire && wr_ok && aw_idx_ff == IDX_RXFREQ |=> rx_synth_word == $past(wr_word))
        else $error("synth word not stored");
    a_steps_write: assert property (@(posedge aclk)
        disable iff (!aresetn || pls.busy)
        wr_fire && wr_ok && aw_idx_ff == IDX_STEPS |=>
        {skip_mask, sdm_enable_mask, mixer_threshold, lna_threshold} == $past(wr_word))
        else $error("steps word not stored");
    a_dur_write: assert property (@(posedge aclk)
        disable iff (!aresetn || pls.busy)
        wr_fire && wr_ok && aw_idx_ff == IDX_DUR |=>
        {offset_adc_range_mask, state2_duration, state1_duration, state0_duration}
        == $past(wr_word)) else $error("duration word not stored");
    // a refused write leaves the synth word alone
    a_refused_keep: assert property (@(posedge aclk)
        disable iff (!aresetn || pls.busy)
        wr_fire && !wr_ok |=> rx_synth_word == $past(rx_synth_word))
        else $error("refused write changed a register");
    // gain recomputed with the literal mode constants
    a_gain_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_gain_db == 8'(gain_ff[6:0] - mode_ff[5:1] + (mode_ff[0] ? 17 : 8)))
        else $error("gain mismatch");
endmodule

// File: sim/tb_top.sv
// self-checking bench for the transceiver control bank
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
    begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
    $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module tb_top;
    import tcr_pkg::*;
    localparam int LEN = 10; // short pulse keeps the run brief
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    // bus wires
    logic [5:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    // bank outputs
    logic txh, txl, rxl, rxh1, rxh2, lvl, crst;
    logic [15:0] synth;
    logic [7:0] gain;
    logic [3:0] skp, sdm, mix, lna, adc, d2, d1, d0, it3;
    int bad_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int pulse = 0;
    int p0;

    always #5 aclk = ~aclk;

    tcr_regs #(.SRST_LEN(LEN)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_high_port(txh),
        .tx_low_port(txl), .rx_low_port(rxl), .rx_high_port_one(rxh1),
        .rx_high_port_two(rxh2), .interface_level_select(lvl), .chip_reset(crst),
        .rx_synth_word(synth), .rx_gain_db(gain), .skip_mask(skp),
        .sdm_enable_mask(sdm), .mixer_threshold(mix), .lna_threshold(lna),
        .offset_adc_range_mask(adc), .state2_duration(d2), .state1_duration(d1),
        .state0_duration(d0), .state3_integrator_constant(it3));

    tcr_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready));

    // verdict and end of run
    task automatic report_and_stop();
        if (bad_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // full-strobe write with expected answer
    task automatic w(input logic [3:0] i, input logic [15:0] d, input logic [1:0] er);
        host.wr(i, d, 4'hf, rsp);
        `CHK("bresp", er, rsp)
    endtask

    // pulse length meter and hang guard; run needs under two hundred cycles
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (crst === 1'b1)
            pulse <= pulse + 1;
        if (cyc == 2000)
        begin
            bad_count++;
            report_and_stop();
        end
    end

    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // soft reset after power-up, busy seen mid-pulse
        w(IDX_LVL, 16'h0000, RESP_OKAY);
        p0 = pulse;
        w(IDX_LVL, 16'h0001, RESP_OKAY);
        host.rd(IDX_STATUS, rd, rsp);
        `CHK("busy", 1'b1, rd[0])
        repeat (LEN + 4) @(posedge aclk);
        `CHK("pulse", LEN, pulse - p0)
        // dirty two registers so the second pulse must put them back
        w(IDX_STEPS, 16'h1234, RESP_OKAY);
        w(IDX_RXFREQ, 16'h4321, RESP_OKAY);
        // bit must have cleared itself: a second 1 relaunches
        p0 = pulse;
        w(IDX_LVL, 16'h0001, RESP_OKAY);
        repeat (LEN + 4) @(posedge aclk);
        `CHK("relaunch", LEN, pulse - p0)
        `CHK("lvl rst", 1'b1, lvl)
        `CHK("synth rst", RST_RXFREQ, synth)
        `CHK("bands rst", 5'h0a, {txh, txl, rxl, rxh1, rxh2})
        `CHK("steps rst", RST_STEPS, {skp, sdm, mix, lna})
        `CHK("dur rst", RST_DUR, {adc, d2, d1, d0})
        `CHK("integ rst", 4'he, it3)
        `CHK("gain rst", 8'h00, gain)
        // every receive select code with tx on high band
        for (int i = 0; i < 4; i++)
        begin
            w(IDX_BAND, 16'h0010 | 16'(i << 1), RESP_OKAY);
            `CHK("rx sel", {i == 1, i == 2, i == 3}, {rxl, rxh1, rxh2})
            `CHK("tx high", 2'h2, {txh, txl})
        end
        w(IDX_BAND, 16'h0004, RESP_OKAY);
        `CHK("tx low", 2'h1, {txh, txl})
        w(IDX_LVL, 16'h0000, RESP_OKAY);
        `CHK("lvl low", 1'b0, lvl)
        w(IDX_LVL, 16'h0002, RESP_OKAY);
        `CHK("lvl high", 1'b1, lvl)
        w(IDX_RXFREQ, 16'h9470, RESP_OKAY);
        `CHK("synth", 16'h9470, synth)
        // gain: upper bits ignored, offset and mode constant applied
        w(IDX_GAIN, 16'hff7f, RESP_OKAY);
        `CHK("gain", 8'h7f, gain)
        w(IDX_MODE, 16'h0007, RESP_OKAY);
        `CHK("gain narrow", 8'h8d, gain)
        w(IDX_MODE, 16'h0006, RESP_OKAY);
        `CHK("gain wide", 8'h84, gain)
        w(IDX_STEPS, 16'h5a3c, RESP_OKAY);
        `CHK("steps", 16'h5a3c, {skp, sdm, mix, lna})
        w(IDX_DUR, 16'h8765, RESP_OKAY);
        `CHK("dur", 16'h8765, {adc, d2, d1, d0})
        w(IDX_INTEG, 16'h9123, RESP_OKAY);
        `CHK("integ", 4'h9, it3)
        // refusals: unmapped index, partial word, write-only read
        w(4'h3, 16'h1234, RESP_SLVERR);
        host.wr(IDX_RXFREQ, 16'h0000, 4'h1, rsp);
        `CHK("strb", RESP_SLVERR, rsp)
        `CHK("kept", 16'h9470, synth)
        host.rd(IDX_RXFREQ, rd, rsp);
        `CHK("wo read", {RESP_SLVERR, 32'h0}, {rsp, rd})
        host.rd(IDX_STATUS, rd, rsp);
        `CHK("idle", {RESP_OKAY, 1'b0}, {rsp, rd[0]})
        report_and_stop();
    end
endmodule

// File: sim/tcr_host.sv
// host model: axi4-lite master standing in for the baseband processor
`timescale 1ns/1ns
module tcr_host
(
    // clock
    input wire logic aclk,
    // write side
    output logic [5:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // read side
    output logic [5:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // idle bus; address and data are scrambled once released, byte enables left stale
    initial
    begin
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 6'h15;
        araddr = 6'h2a;
        wdata = 32'h5a5a5a5a;
        wstrb = 4'h0;
    end

    // one write: index, data word and caller's byte enables, channels released separately
    task automatic wr(input logic [3:0] i, input logic [15:0] d, input logic [3:0] st,
                      output logic [1:0] rsp);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= {i, 2'h0};
        wdata <= {~d, d};
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            // address taken
            if (awvalid && awready)
            begin
                awvalid <= 1'b0;
                awaddr <= ~awaddr;
            end
            // data taken
            if (wvalid && wready)
            begin
                wvalid <= 1'b0;
                wdata <= ~wdata;
            end
            // answer sampled
            if (bvalid)
            begin
                rsp = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    // one read; rready held until the answer is sampled
    task automatic rd(input logic [3:0] i, output logic [31:0] d, output logic [1:0] rsp);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= {i, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (arvalid && arready)
            begin
                arvalid <= 1'b0;
                araddr <= ~araddr;
            end
            if (rvalid)
            begin
                d = rdata;
                rsp = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
endmodule
